/* File: rtl/cal_regs_pkg.sv */
// What this block does
// - gain exponent is fixed at minus sixteen; writes to those bits do nothing
// - gain mantissa accepted from 16 to 508, power-up default 32
// - gain is sense volts per amp and divides the sensed voltage into current
// - writes to read-only bit positions are dropped, writable bits take new data
// - page bits 7 and 0: 00 channel one, 01 channel two, 11 both
// - channel one always writable, channel two only when it is a master
// - slave channel two uses the channel one calibration values
// - lone write to slave channel two is refused, flags invalid command, raises alert
// - power-up defaults are replaced by values committed to the user store
// - offset exponent fixed at minus four, step 62.5 mA, exponent writes dropped
// - offset spans -4 A to 3.9375 A, no range check, out-of-range wraps
// - top five offset mantissa bits always copy the sign bit
// - offset correction feeds reported current and overcurrent comparisons
// - offset powers up at zero amps unless the user store overrides it
package cal_regs_pkg;

    // ----------------------------------------------------------------
    // command codes and page decode
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_GAIN = 8'h38;
    localparam logic [7:0] CMD_OFFSET = 8'h39;
    localparam int PAGE_HI_BIT = 7;
    localparam int PAGE_LO_BIT = 0;
    localparam logic [1:0] SEL_CH1 = 2'h0;
    localparam logic [1:0] SEL_CH2 = 2'h1;
    localparam logic [1:0] SEL_BOTH = 2'h3;

    // ----------------------------------------------------------------
    // linear word layout and fixed values
    // ----------------------------------------------------------------
    localparam int EXP_LSB = 11;
    localparam int MANT_W = 11;
    localparam int OFF_SIGN_BIT = 10;
    localparam int OFF_FREE_W = 6;
    localparam int OFF_EXT_W = 5;
    localparam logic [4:0] GAIN_EXP = 5'h10;
    localparam logic [4:0] OFF_EXP = 5'h1C;
    localparam logic [10:0] GAIN_MANT_MIN = 11'h010;
    localparam logic [10:0] GAIN_MANT_MAX = 11'h1FC;
    localparam logic [10:0] GAIN_MANT_RST = 11'h020;
    localparam logic [10:0] OFF_MANT_RST = 11'h000;
    localparam logic [15:0] GAIN_RST = {GAIN_EXP, GAIN_MANT_RST};
    localparam logic [15:0] OFF_RST = {OFF_EXP, OFF_MANT_RST};

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] offset;
    } cal_pair_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] page;
        logic [15:0] data;
    } host_cmd_s;

    typedef struct packed {
        logic ack;
        logic nack;
        logic [15:0] data;
    } host_rsp_s;

    typedef struct packed {
        logic valid;
        logic [17:0] amps;
        logic oc_fault;
        logic oc_warn;
    } iout_s;

endpackage : cal_regs_pkg

/* File: rtl/cal_word_fix.sv */
`timescale 1ns/100ps
module cal_word_fix
(
    // selection and raw data
    input wire logic is_offset_i,
    input wire logic [15:0] raw_i,
    // cleaned word
    output logic [15:0] word_o
);

    logic [10:0] mant;
    logic sign;

    // gain: exponent forced, mantissa held inside its accepted range
    always_comb
    begin
        mant = raw_i[cal_regs_pkg::MANT_W-1:0];
        if (mant[cal_regs_pkg::OFF_SIGN_BIT] || mant < cal_regs_pkg::GAIN_MANT_MIN)
            mant = cal_regs_pkg::GAIN_MANT_MIN;
        else if (mant > cal_regs_pkg::GAIN_MANT_MAX)
            mant = cal_regs_pkg::GAIN_MANT_MAX;
    end

    assign sign = raw_i[cal_regs_pkg::OFF_SIGN_BIT];

    // offset keeps only sign and low six bits, so big values alias into range
    assign word_o = is_offset_i
        ? {cal_regs_pkg::OFF_EXP, {cal_regs_pkg::OFF_EXT_W{sign}},
           raw_i[cal_regs_pkg::OFF_FREE_W-1:0]}
        : {cal_regs_pkg::GAIN_EXP, mant};

endmodule : cal_word_fix

/* File: rtl/iout_convert.sv */
`timescale 1ns/100ps
module iout_convert
(
    // clock and synchronised reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // sample and calibration
    input wire logic sample_valid_i,
    input wire logic [15:0] vsense_i,
    input wire cal_regs_pkg::cal_pair_s cal_i,
    input wire logic [17:0] oc_fault_limit_i,
    input wire logic [17:0] oc_warn_limit_i,
    // result
    output cal_regs_pkg::iout_s iout_o
);

    typedef enum logic [2:0] {
        CV_IDLE = 3'b001,
        CV_RUN = 3'b010,
        CV_DONE = 3'b100
    } cv_state_e;

    typedef struct packed {
        cv_state_e state;
        logic [4:0] cnt;
        logic [16:0] rem;
        logic [15:0] quo;
        logic [10:0] dvs;
        logic [17:0] off;
        logic neg;
        cal_regs_pkg::iout_s res;
    } cv_s;

    cv_s s_q, s_d;
    logic [16:0] trial;
    logic [17:0] signed_q;
    logic [17:0] sum;

    // one quotient bit per cycle keeps the divider small; a sample takes 18 cycles
    always_comb
    begin
        s_d = s_q;
        s_d.res.valid = 1'b0;
        trial = {s_q.rem[15:0], s_q.quo[15]};
        signed_q = s_q.neg ? 18'(-{2'h0, s_q.quo}) : {2'h0, s_q.quo};
        sum = 18'(signed_q + s_q.off);
        unique case (s_q.state)
            CV_IDLE:
            begin
                if (sample_valid_i)
                begin
                    s_d.neg = vsense_i[15];
                    s_d.quo = vsense_i[15] ? 16'(-vsense_i) : vsense_i;
                    s_d.rem = 17'h00000;
                    s_d.dvs = cal_i.gain[cal_regs_pkg::MANT_W-1:0];
                    s_d.off = {{7{cal_i.offset[cal_regs_pkg::OFF_SIGN_BIT]}},
                               cal_i.offset[cal_regs_pkg::MANT_W-1:0]};
                    s_d.cnt = 5'h00;
                    s_d.state = CV_RUN;
                end
            end
            CV_RUN:
            begin
                // restoring division: current = voltage / resistance
                if (trial >= {6'h00, s_q.dvs})
                begin
                    s_d.rem = 17'(trial - {6'h00, s_q.dvs});
                    s_d.quo = {s_q.quo[14:0], 1'b1};
                end
                else
                begin
                    s_d.rem = trial;
                    s_d.quo = {s_q.quo[14:0], 1'b0};
                end
                s_d.cnt = 5'(s_q.cnt + 5'h01);
                if (s_q.cnt == 5'h0F)
                    s_d.state = CV_DONE;
            end
            CV_DONE:
            begin
                // offset corrects both the reading and the limit checks
                s_d.res.amps = sum;
                s_d.res.oc_fault = $signed(sum) >= $signed(oc_fault_limit_i);
                s_d.res.oc_warn = $signed(sum) >= $signed(oc_warn_limit_i);
                s_d.res.valid = 1'b1;
                s_d.state = CV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '{state: CV_IDLE, default: '0};
        else
            s_q <= s_d;
    end

    assign iout_o = s_q.res;

endmodule : iout_convert

/* File: rtl/current_sense_calibration_regs.sv */
`timescale 1ns/100ps
module current_sense_calibration_regs
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // host command port, one command per valid cycle
    input wire cal_regs_pkg::host_cmd_s cmd_i,
    output cal_regs_pkg::host_rsp_s rsp_o,
    // fault reporting
    input wire logic clear_faults_i,
    output logic invalid_command_fault_o,
    output logic smb_alert_o,
    // multi-phase configuration
    input wire logic ch2_master_i,
    // user store
    input wire logic nvm_valid_i,
    input wire cal_regs_pkg::cal_pair_s [1:0] nvm_cal_i,
    input wire logic store_user_i,
    output logic nvm_wr_o,
    output cal_regs_pkg::cal_pair_s [1:0] nvm_cal_o,
    // calibration in use and measurement path
    output cal_regs_pkg::cal_pair_s [1:0] cal_eff_o,
    input wire logic [1:0] vsense_valid_i,
    input wire logic [1:0][15:0] vsense_i,
    input wire logic [1:0][17:0] oc_fault_limit_i,
    input wire logic [1:0][17:0] oc_warn_limit_i,
    output cal_regs_pkg::iout_s [1:0] iout_o
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    // release is synchronised so every flop leaves reset on the same edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cal_regs_pkg::cal_pair_s [1:0] cal;
        cal_regs_pkg::host_rsp_s rsp;
        logic inv_cmd;
        logic alert;
        logic nvm_wr;
        logic boot_done;
    } top_s;

    top_s s_q, s_d;

    logic [1:0] sel;
    logic is_gain;
    logic is_offset;
    logic hit;
    logic wr_ch1;
    logic wr_ch2;
    logic refuse;
    logic [15:0] fixed_word;
    logic [1:0][15:0] boot_gain;
    logic [1:0][15:0] boot_off;
    cal_regs_pkg::cal_pair_s [1:0] eff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // only the two outer page bits pick the channel
    assign sel = {cmd_i.page[cal_regs_pkg::PAGE_HI_BIT],
                  cmd_i.page[cal_regs_pkg::PAGE_LO_BIT]};
    assign is_gain = cmd_i.code == cal_regs_pkg::CMD_GAIN;
    assign is_offset = cmd_i.code == cal_regs_pkg::CMD_OFFSET;
    assign hit = cmd_i.valid && (is_gain || is_offset);

    // channel one is always open, channel two only as a master
    assign wr_ch1 = sel == cal_regs_pkg::SEL_CH1 || sel == cal_regs_pkg::SEL_BOTH;
    assign wr_ch2 = ch2_master_i
        && (sel == cal_regs_pkg::SEL_CH2 || sel == cal_regs_pkg::SEL_BOTH);

    // a lone slave channel two write, or the unused page pattern, is refused
    assign refuse = hit && cmd_i.write
        && ((sel == cal_regs_pkg::SEL_CH2 && !ch2_master_i) || sel == 2'h2);

    // ----------------------------------------------------------------
    // write cleaning
    // ----------------------------------------------------------------
    cal_word_fix u_fix_host
    (
        .is_offset_i(is_offset),
        .raw_i(cmd_i.data),
        .word_o(fixed_word)
    );

    // stored words are cleaned too, so a bad user store cannot break the format
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_boot
        cal_word_fix u_fix_gain
        (
            .is_offset_i(1'b0),
            .raw_i(nvm_cal_i[ch].gain),
            .word_o(boot_gain[ch])
        );
        cal_word_fix u_fix_off
        (
            .is_offset_i(1'b1),
            .raw_i(nvm_cal_i[ch].offset),
            .word_o(boot_off[ch])
        );
    end

    // ----------------------------------------------------------------
    // effective values
    // ----------------------------------------------------------------
    // a slave channel two follows channel one, its own copy is unused
    always_comb
    begin
        eff[0] = s_q.cal[0];
        eff[1] = ch2_master_i ? s_q.cal[1] : s_q.cal[0];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.rsp.ack = 1'b0;
        s_d.rsp.nack = 1'b0;
        s_d.nvm_wr = 1'b0;
        s_d.boot_done = 1'b1;

        // first edge after release: take the user store over the defaults
        if (!s_q.boot_done && nvm_valid_i)
        begin
            for (int ch = 0; ch < 2; ch++)
            begin
                s_d.cal[ch].gain = boot_gain[ch];
                s_d.cal[ch].offset = boot_off[ch];
            end
        end

        // host writes and reads of the two calibration words
        if (hit && cmd_i.write)
        begin
            if (refuse)
            begin
                s_d.rsp.nack = 1'b1;
            end
            else
            begin
                s_d.rsp.ack = 1'b1;
                if (wr_ch1)
                begin
                    if (is_gain)
                        s_d.cal[0].gain = fixed_word;
                    else
                        s_d.cal[0].offset = fixed_word;
                end
                if (wr_ch2)
                begin
                    if (is_gain)
                        s_d.cal[1].gain = fixed_word;
                    else
                        s_d.cal[1].offset = fixed_word;
                end
            end
        end
        else if (hit)
        begin
            s_d.rsp.ack = 1'b1;
            if (sel == cal_regs_pkg::SEL_CH2)
                s_d.rsp.data = is_gain ? eff[1].gain : eff[1].offset;
            else
                s_d.rsp.data = is_gain ? eff[0].gain : eff[0].offset;
        end

        // fault flags: a new refusal wins over a clear in the same cycle
        if (clear_faults_i)
        begin
            s_d.inv_cmd = 1'b0;
            s_d.alert = 1'b0;
        end
        if (refuse)
        begin
            s_d.inv_cmd = 1'b1;
            s_d.alert = 1'b1;
        end

        // commit the stored copies to the user store
        if (store_user_i)
            s_d.nvm_wr = 1'b1;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.cal[0].gain <= cal_regs_pkg::GAIN_RST;
            s_q.cal[1].gain <= cal_regs_pkg::GAIN_RST;
            s_q.cal[0].offset <= cal_regs_pkg::OFF_RST;
            s_q.cal[1].offset <= cal_regs_pkg::OFF_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // measurement correction, one converter per channel
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_conv
        iout_convert u_conv
        (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n),
            .sample_valid_i(vsense_valid_i[ch]),
            .vsense_i(vsense_i[ch]),
            .cal_i(eff[ch]),
            .oc_fault_limit_i(oc_fault_limit_i[ch]),
            .oc_warn_limit_i(oc_warn_limit_i[ch]),
            .iout_o(iout_o[ch])
        );
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rsp_o = s_q.rsp;
    assign invalid_command_fault_o = s_q.inv_cmd;
    assign smb_alert_o = s_q.alert;
    assign nvm_wr_o = s_q.nvm_wr;
    assign nvm_cal_o = s_q.cal;
    assign cal_eff_o = eff;

endmodule : current_sense_calibration_regs

/* File: test/cal_regs_properties.sv */
`timescale 1ns/100ps
module cal_regs_properties
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // host side
    input wire cal_regs_pkg::host_cmd_s cmd_i,
    input wire cal_regs_pkg::host_rsp_s rsp_o,
    input wire logic clear_faults_i,
    input wire logic invalid_command_fault_o,
    input wire logic smb_alert_o,
    input wire logic ch2_master_i,
    // store and values in use
    input wire logic store_user_i,
    input wire logic nvm_wr_o,
    input wire cal_regs_pkg::cal_pair_s [1:0] cal_eff_o,
    input wire cal_regs_pkg::iout_s [1:0] iout_o,
    input wire logic [1:0][17:0] oc_warn_limit_i
);
    // ----------------------------------------
    // decode of the request being taken
    // ----------------------------------------
    wire logic hit = cmd_i.valid && (cmd_i.code == cal_regs_pkg::CMD_GAIN || cmd_i.code == cal_regs_pkg::CMD_OFFSET);
    wire logic [1:0] sel = {cmd_i.page[7], cmd_i.page[0]};
    // sel 10 is never a channel, so it is refused even for a master
    wire logic refused = hit && cmd_i.write && ((sel == 2'h1 && !ch2_master_i) || sel == 2'h2);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_ack; hit && !refused |=> rsp_o.ack && !rsp_o.nack; endproperty
    a_ack: assert property (p_ack) else $error("accepted command not acked");
    property p_nack; refused |=> rsp_o.nack && !rsp_o.ack && invalid_command_fault_o && smb_alert_o; endproperty
    a_nack: assert property (p_nack) else $error("slave write not refused");
    property p_quiet; !hit |=> !rsp_o.ack && !rsp_o.nack; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without command");
    property p_sticky; invalid_command_fault_o && !clear_faults_i |=> invalid_command_fault_o; endproperty
    a_sticky: assert property (p_sticky) else $error("fault dropped uncleared");
    property p_gain; cal_eff_o[0].gain[15:11] == 5'h10 && cal_eff_o[0].gain[10:0] inside {[11'h010:11'h1FC]}; endproperty
    a_gain: assert property (p_gain) else $error("gain word malformed");
    property p_off; cal_eff_o[0].offset[15:11] == 5'h1C && cal_eff_o[0].offset[9:6] == {4{cal_eff_o[0].offset[10]}};
    endproperty
    a_off: assert property (p_off) else $error("offset word malformed");
    property p_slave; !ch2_master_i |-> cal_eff_o[1] == cal_eff_o[0]; endproperty
    a_slave: assert property (p_slave) else $error("slave not using channel one");
    property p_store; store_user_i |=> nvm_wr_o ##1 !nvm_wr_o; endproperty
    a_store: assert property (p_store) else $error("store commit pulse wrong");
    property p_warn; iout_o[0].valid |-> iout_o[0].oc_warn == ($signed(iout_o[0].amps) >= $signed(oc_warn_limit_i[0]));
    endproperty
    a_warn: assert property (p_warn) else $error("warn flag mismatch");

    c_nack: cover property (refused ##1 rsp_o.nack);
    c_conv: cover property (iout_o[0].valid);
    c_store: cover property (nvm_wr_o);
endmodule : cal_regs_properties

bind current_sense_calibration_regs cal_regs_properties u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cmd_i(cmd_i), .rsp_o(rsp_o), .clear_faults_i(clear_faults_i), .invalid_command_fault_o(invalid_command_fault_o),
    .smb_alert_o(smb_alert_o), .ch2_master_i(ch2_master_i), .store_user_i(store_user_i), .nvm_wr_o(nvm_wr_o),
    .cal_eff_o(cal_eff_o), .iout_o(iout_o), .oc_warn_limit_i(oc_warn_limit_i));

/* File: test/pmbus_host_model.sv */
`timescale 1ns/100ps
module pmbus_host_model
(
    // clock
    input wire logic clk_sys_i,
    // command and answer
    output cal_regs_pkg::host_cmd_s cmd_o,
    input wire cal_regs_pkg::host_rsp_s rsp_i
);
    initial cmd_o = '0;

    // one word per command; gap idles first to act as a slow host
    // matching values across controllers is left to the caller
    task xfer(input logic wr, input logic [7:0] code, input logic [7:0] page, input logic [15:0] data,
              input int gap, output logic ack, output logic nack, output logic [15:0] rdata);
        int i;
        repeat (gap) @(negedge clk_sys_i);
        cmd_o = {1'b1, wr, code, page, data};
        @(negedge clk_sys_i);
        // released fields show junk so stale data cannot pass
        cmd_o = {1'b0, ~wr, ~code, ~page, ~data};
        ack = 1'b0;
        nack = 1'b0;
        rdata = 16'h0000;
        for (i = 0; i < 3; i++)
        begin
            if (rsp_i.ack || rsp_i.nack)
            begin
                ack = rsp_i.ack;
                nack = rsp_i.nack;
                rdata = rsp_i.data;
                break;
            end
            @(negedge clk_sys_i);
        end
    endtask : xfer
endmodule : pmbus_host_model

/* File: test/tb_current_sense_calibration_regs.sv */
`timescale 1ns/100ps
module tb_current_sense_calibration_regs;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    cal_regs_pkg::host_cmd_s cmd;
    cal_regs_pkg::host_rsp_s rsp;
    logic clear_faults_i = 1'b0, fault, alert, ch2_master_i = 1'b0, nvm_valid_i = 1'b0, store_user_i = 1'b0, nvm_wr;
    cal_regs_pkg::cal_pair_s [1:0] nvm_cal_i = {2{16'h0040, 16'h0003}};
    cal_regs_pkg::cal_pair_s [1:0] nvm_cal_o, cal_eff;
    logic [1:0] vsense_valid_i = 2'h0;
    logic [1:0][15:0] vsense_i = {16'hF940, 16'h12C0};
    logic [1:0][17:0] fault_lim = {18'h000C8, 18'h000C8}, warn_lim = {18'h00068, 18'h00068};
    cal_regs_pkg::iout_s [1:0] iout;
    int n_fail = 0, checks_done = 0, k;
    logic ua, un;
    logic [15:0] ur;

    initial forever #25 clk_sys_i = ~clk_sys_i;

    pmbus_host_model u_host (.clk_sys_i(clk_sys_i), .cmd_o(cmd), .rsp_i(rsp));
    current_sense_calibration_regs u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .rsp_o(rsp),
        .clear_faults_i(clear_faults_i), .invalid_command_fault_o(fault), .smb_alert_o(alert),
        .ch2_master_i(ch2_master_i), .nvm_valid_i(nvm_valid_i), .nvm_cal_i(nvm_cal_i), .store_user_i(store_user_i),
        .nvm_wr_o(nvm_wr), .nvm_cal_o(nvm_cal_o), .cal_eff_o(cal_eff), .vsense_valid_i(vsense_valid_i),
        .vsense_i(vsense_i), .oc_fault_limit_i(fault_lim), .oc_warn_limit_i(warn_lim), .iout_o(iout));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task wrap_up;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // write or read one word; a missing answer ends the run
    task acc(input logic wr, input logic [7:0] code, input logic [7:0] page, input logic [15:0] data,
             input logic exp_nack);
        logic a, n;
        logic [15:0] r;
        u_host.xfer(wr, code, page, data, 1, a, n, r);
        chk({14'h0, a, n}, exp_nack ? 16'h0001 : 16'h0002);
        if (!(a || n))
            wrap_up();
        if (!wr)
            chk(r, data);
    endtask : acc

    task do_reset;
        rst_n_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
    endtask : do_reset

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        do_reset();
        acc(0, 8'h38, 8'h00, 16'h8020, 0);
        acc(0, 8'h39, 8'h00, 16'hE000, 0);
        acc(1, 8'h38, 8'h00, 16'h0040, 0);
        acc(0, 8'h38, 8'h00, 16'h8040, 0);
        acc(1, 8'h38, 8'h00, 16'h8005, 0);
        acc(0, 8'h38, 8'h00, 16'h8010, 0);
        acc(1, 8'h38, 8'h00, 16'h01FD, 0);
        acc(0, 8'h38, 8'h00, 16'h81FC, 0);
        acc(1, 8'h39, 8'h00, 16'hE401, 0);
        acc(0, 8'h39, 8'h00, 16'hE7C1, 0);
        acc(1, 8'h39, 8'h00, 16'h0005, 0);
        acc(0, 8'h39, 8'h00, 16'hE005, 0);
        // channel two as slave: refused, flagged, mirrors channel one
        acc(1, 8'h38, 8'h01, 16'h0100, 1);
        chk({14'h0, fault, alert}, 16'h0003);
        acc(0, 8'h38, 8'h01, 16'h81FC, 0);
        clear_faults_i = 1'b1;
        @(negedge clk_sys_i);
        clear_faults_i = 1'b0;
        @(negedge clk_sys_i);
        chk({14'h0, fault, alert}, 16'h0000);
        acc(1, 8'h38, 8'h80, 16'h0100, 1);
        // a code outside the two calibration words gets no answer at all
        u_host.xfer(1, 8'h46, 8'h00, 16'h1234, 1, ua, un, ur);
        chk({14'h0, ua, un}, 16'h0000);
        // channel two as master: own value, then both at once
        ch2_master_i = 1'b1;
        acc(1, 8'h38, 8'h01, 16'h0100, 0);
        acc(0, 8'h38, 8'h01, 16'h8100, 0);
        acc(0, 8'h38, 8'h00, 16'h81FC, 0);
        acc(1, 8'h38, 8'h81, 16'h0030, 0);
        for (k = 0; k < 2; k++)
            acc(0, 8'h38, {7'h00, k[0]}, 16'h8030, 0);
        // 4800 / 48 + 5 = 105 amps lsb, above warn 104, below fault 200
        // channel two: -1728 / 48 + 0 = -36, below both limits
        vsense_valid_i = 2'h3;
        @(negedge clk_sys_i);
        vsense_valid_i = 2'h0;
        for (k = 0; k < 30 && !iout[0].valid; k++)
            @(negedge clk_sys_i);
        chk({15'h0, iout[0].valid}, 16'h0001);
        chk(iout[0].amps[15:0], 16'h0069);
        chk({14'h0, iout[0].oc_fault, iout[0].oc_warn}, 16'h0001);
        chk(iout[1].amps[15:0], 16'hFFDC);
        chk({14'h0, iout[1].oc_fault, iout[1].oc_warn}, 16'h0000);
        // commit to the user store, then power up from the preset nvm_cal_i image, gain 0040 and offset 0003
        store_user_i = 1'b1;
        @(negedge clk_sys_i);
        store_user_i = 1'b0;
        for (k = 0; k < 3 && !nvm_wr; k++)
            @(negedge clk_sys_i);
        chk({15'h0, nvm_wr}, 16'h0001);
        chk(nvm_cal_o[0].gain, 16'h8030);
        chk(nvm_cal_o[1].gain, 16'h8030);
        nvm_valid_i = 1'b1;
        do_reset();
        acc(0, 8'h38, 8'h00, 16'h8040, 0);
        acc(0, 8'h39, 8'h01, 16'hE003, 0);
        wrap_up();
    end
endmodule : tb_current_sense_calibration_regs
